/* File: dv/ecdio_ctl_model.sv */
`timescale 1ns/100ps
module ecdio_ctl_model (
    // clock
    input wire logic clock,
    // command from bench
    input wire logic go,
    input wire logic [7:0] lines,
    input wire logic [3:0] low_len,
    // pins and status
    output logic [7:0] ext_in,
    output logic busy
);
    logic [3:0] cnt_r;
    initial begin
        ext_in = 8'hff;
        busy = 1'b0;
    end
    // falling edge command
    // lines pulled low for low_len plus one cycles, then back to the pull-up level
    always @(posedge clock) begin
        if (go && !busy) begin
            ext_in <= ~lines;
            busy <= 1'b1;
            cnt_r <= low_len;
        end else if (busy && cnt_r == 4'h0) begin
            ext_in <= 8'hff;
            busy <= 1'b0;
        end else if (busy) cnt_r <= cnt_r - 4'h1;
    end
endmodule : ecdio_ctl_model

/* File: dv/ecdio_props.sv */
`timescale 1ns/100ps
module ecdio_props (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // pins and strobes
    input wire logic [7:0] ext_in,
    input wire logic [7:0] ext_out,
    input wire logic [3:0] reserved_out,
    input wire logic seq_branch_pulse,
    input wire logic seq_branch_sel
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic [3:0] age0_r;
    logic [3:0] age1_r;
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ctrl_wr;
        wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_adr_i == 8'h04;
    endsequence
    // cycles since each branch trigger fell, saturating so stale edges never match
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            age0_r <= 4'hf;
            age1_r <= 4'hf;
        end else begin
            age0_r <= (age0_r == 4'hf) ? 4'hf : age0_r + 4'h1;
            age1_r <= (age1_r == 4'hf) ? 4'hf : age1_r + 4'h1;
            if ($fell(ext_in[6])) age0_r <= 4'h0;
            if ($fell(ext_in[7])) age1_r <= 4'h0;
        end
    end
    a_unused_low: assert property (
        ext_out[7:6] == 2'h0 && reserved_out == 4'h0) else $error("unused outputs driven");
    a_ack_follows: assert property (
        s_req |=> wb_ack_o) else $error("no ack after request");
    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_status_drive: assert property (
        s_ctrl_wr |-> ##2 {ext_out[5:2], ext_out[0]} == $past(wb_dat_i[4:0], 2))
        else $error("status lines not driven from control");
    a_force_off: assert property (
        $fell(ext_in[1]) |-> ##[3:8] !ext_out[1]) else $error("forced off ignored");
    a_force_on: assert property (
        $fell(ext_in[2]) && ext_in[1] |-> ##[3:8] ext_out[1]) else $error("forced on ignored");
    a_branch_cause: assert property (
        seq_branch_pulse |=> (seq_branch_sel ? age1_r < 4'hc : age0_r < 4'hc))
        else $error("branch choice without trigger");
endmodule : ecdio_props
bind ecdio_top ecdio_props i_ecdio_props (.clock, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .ext_in, .ext_out, .reserved_out,
    .seq_branch_pulse, .seq_branch_sel);

/* File: dv/tb.sv */
`timescale 1ns/100ps
`include "ecdio_map.svh"
module tb;
    logic clock, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, go, mbusy;
    logic seq_branch_pulse, seq_branch_sel;
    logic [7:0] wb_adr_i, ext_in, ext_out, lines, lf;
    logic [3:0] wb_sel_i, reserved_out, low_len;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    int num_errors, tests_run;
    int br_cnt = 0;
    logic [4:0] cv;
    ecdio_top i_ecdio_top (.clock, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_in, .ext_out, .reserved_out,
        .seq_branch_pulse, .seq_branch_sel, .irq);
    ecdio_ctl_model i_ecdio_ctl_model (.clock, .go, .lines, .low_len, .ext_in, .busy(mbusy));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // branch strobes are one cycle wide, so count them as they pass
    always @(posedge clock) if (seq_branch_pulse === 1'b1) br_cnt <= br_cnt + 1;
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : nxt
    function automatic logic [7:0] exp_out(input logic [4:0] c, input logic o);
        return {2'h0, c[4:1], o, c[0]};
    endfunction : exp_out
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h", $time, m, got);
        end
    endtask : chk
    task automatic tmo(input int n);
        if (n >= 30) begin
            num_errors++;
            $display("[ERR] %0t wait ran out", $time);
            finish_test();
        end
    endtask : tmo
    // one classic cycle, entered just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 30);
        tmo(n);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clock);
    endtask : wb
    // random low time of 3 to 6 cycles; 8 cycles covers the sync and update path
    task automatic pin(input logic [7:0] m);
        int n;
        lf = nxt(lf);
        go <= 1'b1;
        lines <= m;
        low_len <= {2'h0, lf[1:0]} + 4'h2;
        @(posedge clock);
        go <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (mbusy !== 1'b0 && n < 30);
        tmo(n);
        repeat (8) @(posedge clock);
    endtask : pin
    initial begin
        {nrst, wb_cyc_i, wb_stb_i, wb_we_i, go} = 5'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i, lines} = 52'h0;
        low_len = 4'h2;
        lf = 8'h45;
        num_errors = 0;
        tests_run = 0;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        chk({24'h0, ext_out}, 32'h0, "outputs at reset");
        chk({28'h0, reserved_out}, 32'h0, "reserved low");
        wb(1'b0, `ECDIO_OFF_STATUS, 32'h0, 4'hf);
        chk(q, 32'h0, "status at reset");
        wb(1'b0, 8'h20, 32'h0, 4'hf);
        chk(q, 32'h0, "unmapped read");
        wb(1'b0, `ECDIO_OFF_PINS, 32'h0, 4'hf);
        chk(q, 32'hff, "idle input levels");
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            lf = nxt(lf);
            wb(1'b1, `ECDIO_OFF_CTRL, {27'h0, lf[4:0]}, 4'h1);
            // pin register follows the control write by one more edge
            @(posedge clock);
            chk({24'h0, ext_out}, {24'h0, exp_out(lf[4:0], 1'b0)}, "status lines");
        end
        wb(1'b1, `ECDIO_OFF_CTRL, 32'h1f, 4'he);
        wb(1'b0, `ECDIO_OFF_CTRL, 32'h0, 4'hf);
        chk(q, {27'h0, lf[4:0]}, "write without lane");
        // pin task steps the lfsr, so keep the control value apart
        cv = lf[4:0];
        $display("test status done");
        wb(1'b1, `ECDIO_OFF_IRQ_MASK, 32'hff, 4'h1);
        pin(8'h04);
        chk({24'h0, ext_out}, {24'h0, exp_out(cv, 1'b1)}, "forced on");
        chk({31'h0, irq}, 32'h1, "irq raised");
        wb(1'b1, `ECDIO_OFF_IRQ_STAT, 32'h04, 4'h1);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        wb(1'b1, `ECDIO_OFF_IRQ_MASK, 32'h0, 4'h1);
        pin(8'h06);
        chk({24'h0, ext_out}, {24'h0, exp_out(cv, 1'b0)}, "off beats on");
        chk({31'h0, irq}, 32'h0, "irq masked");
        wb(1'b1, `ECDIO_OFF_IRQ_STAT, 32'hff, 4'h1);
        pin(8'h01);
        wb(1'b0, `ECDIO_OFF_IRQ_STAT, 32'h0, 4'hf);
        chk(q, 32'h0, "undefined line ignored");
        $display("test pins done");
        pin(8'h80);
        chk(br_cnt, 0, "branch while idle");
        pin(8'h08);
        wb(1'b0, `ECDIO_OFF_STATUS, 32'h0, 4'hf);
        chk({29'h0, q[7:5]}, 32'h2, "running");
        pin(8'h20);
        wb(1'b0, `ECDIO_OFF_STATUS, 32'h0, 4'hf);
        chk({29'h0, q[7:5]}, 32'h4, "held");
        pin(8'h08);
        pin(8'h80);
        chk({31'h0, seq_branch_sel}, 32'h1, "branch one");
        pin(8'h40);
        chk({31'h0, seq_branch_sel}, 32'h0, "branch zero");
        pin(8'hc0);
        chk(br_cnt, 3, "branch count");
        pin(8'h10);
        wb(1'b0, `ECDIO_OFF_STATUS, 32'h0, 4'hf);
        chk({29'h0, q[7:5]}, 32'h0, "stopped");
        $display("test sequence done");
        // reset with the sequence already stopped must clear pins, flags and status
        nrst <= 1'b0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        chk({20'h0, reserved_out, ext_out}, 32'h0, "outputs after reset");
        chk({31'h0, irq}, 32'h0, "irq after reset");
        wb(1'b0, `ECDIO_OFF_IRQ_STAT, 32'h0, 4'hf);
        chk(q, 32'h0, "flags after reset");
        wb(1'b0, `ECDIO_OFF_STATUS, 32'h0, 4'hf);
        chk(q, 32'h0, "status after reset");
        $display("test reset again done");
        finish_test();
    end
endmodule : tb

/* File: hw/ecdio_fall_det.sv */
`timescale 1ns/100ps
`include "ecdio_map.svh"
module ecdio_fall_det (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // raw pins
    input wire logic [7:0] pins_in,
    // filtered level and edge pulses
    output logic [7:0] level,
    ecdio_evt_if.det evt
);
    logic [7:0] s1_r, s2_r, s3_r, lvl_r;
    logic [7:0] agree;
    // a change only counts once stages two and three agree
    assign agree = ~(s2_r ^ s3_r);
    assign level = lvl_r;
    // fall pulse when the accepted level goes high to low
    assign evt.fall = lvl_r & agree & ~s3_r;
    // three stage synchroniser, pins idle high
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1_r <= `ECDIO_RST_IN;
            s2_r <= `ECDIO_RST_IN;
            s3_r <= `ECDIO_RST_IN;
            lvl_r <= `ECDIO_RST_IN;
        end else begin
            s1_r <= pins_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= (agree & s3_r) | (~agree & lvl_r);
        end
    end
endmodule : ecdio_fall_det

/* File: hw/ecdio_top.sv */
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/100ps
`include "ecdio_map.svh"
// What this block does
// R1: eight command input lines and eight status output lines
// R2: falling edges on off, on, start, stop, hold inputs act as commands
// R3: power, output, overload, busy status lines, one means active
// R4: falling edge on branch trigger zero takes branch choice zero; the code takes it only while the sequence runs
// R5: falling edge on branch trigger one takes branch choice one; the code takes it only while running, and zero wins a tie
// R6: undefined and reserved outputs low, undefined input ignored
module ecdio_top
    import ecdio_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // external control port
    input wire logic [7:0] ext_in,
    output logic [7:0] ext_out,
    output logic [3:0] reserved_out,
    // sequence engine strobes
    output logic seq_branch_pulse,
    output logic seq_branch_sel,
    // interrupt
    output logic irq
);
    ecdio_evt_if evt_bus ();
    logic [7:0] in_level;
    logic [7:0] ctrl_r, irq_stat_r, irq_mask_r, ext_out_r;
    logic [7:0] irq_stat_nxt, irq_mask_nxt;
    logic outp_r, outp_nxt;
    logic [31:0] dat_r;
    logic ack_r, irq_r, br_pulse_r, br_sel_r;
    ecdio_seq_type seq_r, seq_nxt;
    logic wr_go, wr_ctrl, wr_stat, wr_mask, req, rd_hit;
    logic [31:0] rd_mux;
    logic [7:0] events;
    logic ev_foff, ev_fon, ev_start, ev_stop, ev_hold, ev_br0, ev_br1;
    logic sw_set, sw_clr;
    logic [7:0] out_nxt;

    // byte lane zero carries every register
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction : hit

    // R1: eight command lines in, all synchronised
    ecdio_fall_det u_det (
        .clock(clock),
        .nrst(nrst),
        .pins_in(ext_in),
        .level(in_level),
        .evt(evt_bus.det)
    );

    // R2: command edge decode
    assign ev_foff = evt_bus.fall[`ECDIO_IN_FOFF];
    assign ev_fon = evt_bus.fall[`ECDIO_IN_FON];
    assign ev_start = evt_bus.fall[`ECDIO_IN_START];
    assign ev_stop = evt_bus.fall[`ECDIO_IN_STOP];
    assign ev_hold = evt_bus.fall[`ECDIO_IN_HOLD];
    // R4: branch zero edge
    assign ev_br0 = evt_bus.fall[`ECDIO_IN_BR0];
    // R5: branch one edge
    assign ev_br1 = evt_bus.fall[`ECDIO_IN_BR1];
    // R6: undefined input masked out of events
    assign events = {evt_bus.fall[7:1], 1'b0};

    // bus decode; ack follows the request by one cycle and lasts one cycle
    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    // writes land at the edge that samples ack, while the master still holds them
    assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];
    assign wr_ctrl = wr_go & hit(wb_adr_i, `ECDIO_OFF_CTRL);
    assign wr_stat = wr_go & hit(wb_adr_i, `ECDIO_OFF_IRQ_STAT);
    assign wr_mask = wr_go & hit(wb_adr_i, `ECDIO_OFF_IRQ_MASK);
    assign sw_set = wr_ctrl & wb_dat_i[`ECDIO_CTRL_OUT_SET];
    assign sw_clr = wr_ctrl & wb_dat_i[`ECDIO_CTRL_OUT_CLR];
    assign rd_hit = hit(wb_adr_i, `ECDIO_OFF_STATUS) | hit(wb_adr_i, `ECDIO_OFF_CTRL)
        | hit(wb_adr_i, `ECDIO_OFF_IRQ_STAT) | hit(wb_adr_i, `ECDIO_OFF_IRQ_MASK)
        | hit(wb_adr_i, `ECDIO_OFF_PINS);
    // unmapped addresses read zero and still ack
    assign rd_mux = !rd_hit ? `ECDIO_RST_WORD :
        hit(wb_adr_i, `ECDIO_OFF_STATUS) ? {24'h000000, seq_r == ECDIO_SEQ_HOLD,
            seq_r == ECDIO_SEQ_RUN, br_sel_r, ext_out_r[4:0]} :
        hit(wb_adr_i, `ECDIO_OFF_CTRL) ? {24'h000000, ctrl_r} :
        hit(wb_adr_i, `ECDIO_OFF_IRQ_STAT) ? {24'h000000, irq_stat_r} :
        hit(wb_adr_i, `ECDIO_OFF_IRQ_MASK) ? {24'h000000, irq_mask_r} :
        {24'h000000, in_level};

    // R2: forced off wins over forced on; software next
    assign outp_nxt = ev_foff ? 1'b0 : ev_fon ? 1'b1 : sw_clr ? 1'b0 : sw_set ? 1'b1 : outp_r;

    // R2: sequence start, stop and hold
    always_comb begin
        seq_nxt = seq_r;
        case (seq_r)
            ECDIO_SEQ_IDLE: begin
                if (ev_start) begin
                    seq_nxt = ECDIO_SEQ_RUN;
                end
            end
            ECDIO_SEQ_RUN: begin
                if (ev_stop) begin
                    seq_nxt = ECDIO_SEQ_IDLE;
                end else if (ev_hold) begin
                    seq_nxt = ECDIO_SEQ_HOLD;
                end
            end
            ECDIO_SEQ_HOLD: begin
                if (ev_stop) begin
                    seq_nxt = ECDIO_SEQ_IDLE;
                end else if (ev_start) begin
                    seq_nxt = ECDIO_SEQ_RUN;
                end
            end
            default: begin
                seq_nxt = ECDIO_SEQ_IDLE;
            end
        endcase
    end

    // R3: status lines, one means on, overload or busy
    assign out_nxt = {2'b00, ctrl_r[`ECDIO_CTRL_SYNC1], ctrl_r[`ECDIO_CTRL_SYNC0],
        ctrl_r[`ECDIO_CTRL_BUSY], ctrl_r[`ECDIO_CTRL_OVL], outp_r,
        ctrl_r[`ECDIO_CTRL_PWR]};

    // sticky flags: a new event beats the write-one clear
    assign irq_stat_nxt = events | (irq_stat_r & ~(wr_stat ? wb_dat_i[7:0] : 8'h00));
    assign irq_mask_nxt = wr_mask ? wb_dat_i[7:0] : irq_mask_r;

    // bus answer registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ack_r <= 1'b0;
            dat_r <= `ECDIO_RST_WORD;
        end else begin
            ack_r <= req;
            dat_r <= rd_mux;
        end
    end

    // software control and interrupt registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= `ECDIO_RST_BYTE;
            irq_mask_r <= `ECDIO_RST_BYTE;
            irq_stat_r <= `ECDIO_RST_BYTE;
            irq_r <= 1'b0;
        end else begin
            // set and clear strobes self clear
            if (wr_ctrl) begin
                ctrl_r <= {3'b000, wb_dat_i[4:0]};
            end
            irq_mask_r <= irq_mask_nxt;
            irq_stat_r <= irq_stat_nxt;
            // next mask too, so irq never lags a mask write
            irq_r <= |(irq_stat_nxt & irq_mask_nxt);
        end
    end

    // output state, sequence and pin register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            outp_r <= 1'b0;
            seq_r <= ECDIO_SEQ_IDLE;
            ext_out_r <= `ECDIO_RST_BYTE;
        end else begin
            outp_r <= outp_nxt;
            seq_r <= seq_nxt;
            ext_out_r <= out_nxt;
        end
    end

    // R4: branch zero only while running
    // R5: branch one only while running, zero wins a tie
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            br_pulse_r <= 1'b0;
            br_sel_r <= 1'b0;
        end else begin
            br_pulse_r <= (seq_r == ECDIO_SEQ_RUN) & (ev_br0 | ev_br1);
            if ((seq_r == ECDIO_SEQ_RUN) & (ev_br0 | ev_br1)) begin
                br_sel_r <= ~ev_br0;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign ext_out = ext_out_r;
    // R6: reserved outputs held low
    assign reserved_out = 4'h0;
    assign seq_branch_pulse = br_pulse_r;
    assign seq_branch_sel = br_sel_r;
    assign irq = irq_r;
endmodule : ecdio_top

/* File: inc/ecdio_evt_if.sv */
`timescale 1ns/100ps
interface ecdio_evt_if;
    logic [7:0] fall;
    modport det (output fall);
    modport core (input fall);
endinterface : ecdio_evt_if

/* File: inc/ecdio_map.svh */
`ifndef ECDIO_MAP_SVH
`define ECDIO_MAP_SVH
// register byte offsets
`define ECDIO_OFF_STATUS 8'h00
`define ECDIO_OFF_CTRL 8'h04
`define ECDIO_OFF_IRQ_STAT 8'h08
`define ECDIO_OFF_IRQ_MASK 8'h0c
`define ECDIO_OFF_PINS 8'h10
// input line positions (pin 10 maps to bit 0)
`define ECDIO_IN_UNDEF 0
`define ECDIO_IN_FOFF 1
`define ECDIO_IN_FON 2
`define ECDIO_IN_START 3
`define ECDIO_IN_STOP 4
`define ECDIO_IN_HOLD 5
`define ECDIO_IN_BR0 6
`define ECDIO_IN_BR1 7
// output line positions (pins 1..8 map to bits 0..7)
`define ECDIO_OUT_PWR 0
`define ECDIO_OUT_OUTP 1
`define ECDIO_OUT_OVL 2
`define ECDIO_OUT_BUSY 3
`define ECDIO_OUT_SYNC0 4
`define ECDIO_OUT_SYNC1 5
// control register field positions
`define ECDIO_CTRL_PWR 0
`define ECDIO_CTRL_OVL 1
`define ECDIO_CTRL_BUSY 2
`define ECDIO_CTRL_SYNC0 3
`define ECDIO_CTRL_SYNC1 4
`define ECDIO_CTRL_OUT_SET 5
`define ECDIO_CTRL_OUT_CLR 6
// reset values
`define ECDIO_RST_BYTE 8'h00
`define ECDIO_RST_IN 8'hff
`define ECDIO_RST_WORD 32'h0000_0000
`endif

/* File: inc/ecdio_pkg.sv */
package ecdio_pkg;
    // sequence engine states
    typedef enum logic [2:0] {
        ECDIO_SEQ_IDLE = 3'b001,
        ECDIO_SEQ_RUN = 3'b010,
        ECDIO_SEQ_HOLD = 3'b100
    } ecdio_seq_type;
endpackage : ecdio_pkg
